//--- hdl/qadc_defines.vh
// constants of the four-channel converter sequencer
`ifndef QADC_DEFINES_VH
`define QADC_DEFINES_VH

// result, control word, counter and state widths
`define QADC_RES_W      10
`define QADC_CTRL_W     8
`define QADC_CNT_W      5
`define QADC_STATE_W    2

// falling-edge positions within one conversion
`define QADC_CNT_ZERO   5'h00
`define QADC_FALL_FIRST 5'h01
`define QADC_FALL_HOLD  5'h04
`define QADC_FALL_MSB   5'h05
`define QADC_FALL_LSB   5'h0e
`define QADC_FALL_LAST  5'h10

// rising-edge positions within one conversion
`define QADC_RISE_ONE   5'h01
`define QADC_RISE_CTRL  5'h08
`define QADC_RISE_LAST  5'h10

// control word channel field (bits 5..3, top bit ignored)
`define QADC_CHAN_HI    4
`define QADC_CHAN_LO    3
`define QADC_CHAN_RST   2'h0
`define QADC_CTRL_RST   8'h00

// successive approximation
`define QADC_MSB_MASK   10'h200
`define QADC_RES_RST    10'h000

`endif

//--- hdl/qadc_sync.v
// two-flop synchroniser for pin inputs
`default_nettype none
module qadc_sync #(
	parameter       W       = 3,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input  wire         sys_clk,
	input  wire         resetn,
	// pins in, synchronised levels out
	input  wire [W-1:0] pinIn,
	output wire [W-1:0] syncOut
);

	reg [W-1:0] stage1_r;
	reg [W-1:0] stage2_r;

	always @(posedge sys_clk) begin
		if (!resetn) begin
			stage1_r <= RST_VAL;
			stage2_r <= RST_VAL;
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;

endmodule // qadc_sync
`default_nettype wire

//--- hdl/qadc_sar.v
// bit-serial successive-approximation engine
`default_nettype none
`include "qadc_defines.vh"
module qadc_sar (
	// clock and reset
	input  wire                   sys_clk,
	input  wire                   resetn,
	// control from the sequencer
	input  wire                   start,
	input  wire                   step,
	input  wire [`QADC_RES_W-1:0] sample,
	// decided bit and accumulated code
	output wire                   bitNow,
	output wire [`QADC_RES_W-1:0] result
);

	reg [`QADC_RES_W-1:0] sample_r;
	reg [`QADC_RES_W-1:0] mask_r;
	reg [`QADC_RES_W-1:0] result_r;
	wire [`QADC_RES_W-1:0] trial;

	// comparator: keep the trial bit while the held sample reaches it
	assign trial  = result_r | mask_r;
	assign bitNow = (mask_r != `QADC_RES_RST) && (sample_r >= trial);
	assign result = result_r;

	always @(posedge sys_clk) begin
		if (!resetn) begin
			sample_r <= `QADC_RES_RST;
			mask_r   <= `QADC_RES_RST;
			result_r <= `QADC_RES_RST;
		end else if (start) begin
			sample_r <= sample;
			mask_r   <= `QADC_MSB_MASK;
			result_r <= `QADC_RES_RST;
		end else if (step) begin
			if (bitNow)
				result_r <= trial;
			mask_r <= mask_r >> 1;
		end
	end

endmodule // qadc_sar
`default_nettype wire

//--- hdl/qadc_serial_sequencer.v
// conversion sequencer and serial port of the four-channel converter
//
// What this block does
// R01 - a frame is the interval while chip select is held low
// R02 - host gives a multiple of 16 rising clock edges per frame
// R03 - first three clock cycles of a conversion track the selected input
// R04 - cycles four to fifteen hold the sample and convert it
// R05 - serial output driven only while chip select is low
// R06 - result goes out msb first from the fifth clock, straight binary
// R07 - result is ten bits, one step per 1024th of full scale
// R08 - back-to-back conversions retrack after each sixteenth edge, hold at fourth
// R09 - clock gated off while deselected; select fall with clock low counts
// R10 - with clock idling high, tracking starts on first real falling edge
// R11 - first eight rising edges of each conversion shift in the control word
// R12 - channel written now applies to the following conversion
// R13 - control bits 5..3 select the channel, other bits ignored
// R14 - top select bit ignored; low two bits pick inputs a to d
// R15 - no warm-up needed; first conversion after power-up uses input a
// R16 - powered down while deselected and between conversions
// R17 - edges of select and clock too close may delay capture by a clock
// R18 - power-down from sixteenth falling edge to next conversion's first
// R19 - output bit changes after a falling edge, sampled on next rise
// R20 - output low on cycles one to four and the two after the lsb
// R21 - channel field registered on a complete word, resets to input a
`default_nettype none
`include "qadc_defines.vh"
module qadc_serial_sequencer (
	// clock and reset
	input  wire                    sys_clk,
	input  wire                    resetn,
	// serial pins from the host
	input  wire                    chipSelN,
	input  wire                    serialClk,
	input  wire                    serialIn,
	// serial output pin, driven while the enable is high
	output wire                    serialOut,
	output wire                    serialOutOe,
	// digitised stand-ins for the four analog inputs
	input  wire [`QADC_RES_W-1:0]  analogInputA,
	input  wire [`QADC_RES_W-1:0]  analogInputB,
	input  wire [`QADC_RES_W-1:0]  analogInputC,
	input  wire [`QADC_RES_W-1:0]  analogInputD,
	// converter mode
	output wire                    trackActive,
	output wire                    holdActive,
	output wire                    powerDown,
	// status
	output wire [1:0]              chanSelect,
	output wire [`QADC_CTRL_W-1:0] controlWord,
	output wire [`QADC_RES_W-1:0]  lastResult,
	output wire                    resultDone
);

	localparam [`QADC_STATE_W-1:0] ST_PDOWN = 2'h0;
	localparam [`QADC_STATE_W-1:0] ST_TRACK = 2'h1;
	localparam [`QADC_STATE_W-1:0] ST_HOLD  = 2'h2;

	// synchronised pins and their delayed copies
	wire [2:0]                  pinSync;
	wire                        csSync;
	wire                        sclkSync;
	wire                        dinSync;
	reg                         csDly_r;
	reg                         sclkDly_r;

	// edge detection
	wire                        frameOn;
	wire                        csFall;
	wire                        sclkFallRaw;
	wire                        sclkRiseRaw;
	wire                        intFall;
	wire                        intRise;

	// sequencer state
	reg [`QADC_STATE_W-1:0]     state_r;
	reg [`QADC_STATE_W-1:0]     state_nxt;
	reg [`QADC_CNT_W-1:0]       fallCnt_r;
	reg [`QADC_CNT_W-1:0]       fallCnt_nxt;
	reg [`QADC_CNT_W-1:0]       riseCnt_r;
	reg [`QADC_CNT_W-1:0]       riseCnt_nxt;
	reg [`QADC_CNT_W-1:0]       fallNow;
	wire [`QADC_CNT_W-1:0]      riseNow;

	// phase strobes decoded from the edge counters
	wire                        fallTrack;
	wire                        fallHold;
	wire                        fallBit;
	wire                        fallLast;
	wire                        riseTake;
	wire                        riseCtrl;
	wire                        wordFull;

	// control word and channel selection
	reg [`QADC_CTRL_W-1:0]      shift_r;
	reg [`QADC_CTRL_W-1:0]      shift_nxt;
	reg [`QADC_CTRL_W-1:0]      ctrlWord_r;
	reg [`QADC_CTRL_W-1:0]      ctrlWord_nxt;
	reg [1:0]                   chanNext_r;
	reg [1:0]                   chanNext_nxt;
	reg [1:0]                   chanCur_r;
	reg [1:0]                   chanCur_nxt;

	// sampling, output and results
	reg [`QADC_RES_W-1:0]       sample_r;
	reg [`QADC_RES_W-1:0]       sample_nxt;
	reg [`QADC_RES_W-1:0]       chanMux;
	reg                         doutBit_r;
	reg                         doutBit_nxt;
	reg                         doutOe_r;
	reg [`QADC_RES_W-1:0]       lastResult_r;
	reg [`QADC_RES_W-1:0]       lastResult_nxt;
	reg                         done_r;
	reg                         done_nxt;

	// converter engine handshake
	reg                         sarStart;
	reg                         sarStep;
	wire                        sarBit;
	wire [`QADC_RES_W-1:0]      sarResult;

	// the select pin resets high so the port comes up deselected
	qadc_sync #(
		.W       (3),
		.RST_VAL (3'h1)
	) u_pinSync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.pinIn   ({serialIn, serialClk, chipSelN}),
		.syncOut (pinSync)
	);

	assign csSync   = pinSync[0];
	assign sclkSync = pinSync[1];
	assign dinSync  = pinSync[2];

	always @(posedge sys_clk) begin
		if (!resetn) begin
			csDly_r   <= 1'b1;
			sclkDly_r <= 1'b0;
		end else begin
			csDly_r   <= csSync;
			sclkDly_r <= sclkSync;
		end
	end

	// frame is the low interval of select
	assign frameOn     = ~csSync;                                     // [R01]
	assign csFall      = csDly_r & ~csSync;
	assign sclkFallRaw = sclkDly_r & ~sclkSync;
	assign sclkRiseRaw = ~sclkDly_r & sclkSync;

	// internal clock: gated by select, and a select fall with the clock
	// low is itself the first falling edge
	assign intFall = frameOn &                                        // [R09]
		(sclkFallRaw | (csFall & ~sclkSync));                         // [R10] [R17]
	assign intRise = frameOn & sclkRiseRaw &
		(fallCnt_r != `QADC_CNT_ZERO);

	// selected input, field already reduced to its low two bits
	always @* begin
		case (chanCur_r)                                              // [R14]
		2'h0:    chanMux = analogInputA;
		2'h1:    chanMux = analogInputB;
		2'h2:    chanMux = analogInputC;
		default: chanMux = analogInputD;
		endcase
	end

	qadc_sar u_sar (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.start   (sarStart),
		.step    (sarStep),
		.sample  (sample_r),
		.bitNow  (sarBit),
		.result  (sarResult)
	);

	// falling-edge position reached by this edge
	always @* begin
		fallNow = fallCnt_r;
		if (intFall) begin
			// a falling edge after the sixteenth starts a new conversion
			if (fallCnt_r == `QADC_CNT_ZERO ||
				fallCnt_r == `QADC_FALL_LAST)                 // [R08]
				fallNow = `QADC_FALL_FIRST;
			else
				fallNow = fallCnt_r + `QADC_FALL_FIRST;
		end
	end

	// phase strobes, each valid only in the cycle of its edge
	assign riseNow   = riseCnt_r + `QADC_RISE_ONE;
	assign fallTrack = intFall & (fallNow == `QADC_FALL_FIRST);
	assign fallHold  = intFall & (fallNow == `QADC_FALL_HOLD);
	assign fallBit   = intFall & (fallNow >= `QADC_FALL_MSB) &
		(fallNow <= `QADC_FALL_LSB);
	assign fallLast  = intFall & (fallNow == `QADC_FALL_LAST);
	// rises past the sixteenth of a conversion shift nothing
	assign riseTake  = intRise & (riseCnt_r < `QADC_RISE_LAST);
	assign riseCtrl  = riseTake & (riseCnt_r < `QADC_RISE_CTRL);
	assign wordFull  = riseCtrl & (riseNow == `QADC_RISE_CTRL);

	// mode sequencing and edge counters
	always @* begin
		state_nxt   = state_r;
		fallCnt_nxt = fallCnt_r;
		riseCnt_nxt = riseCnt_r;
		chanCur_nxt = chanCur_r;
		if (!frameOn) begin
			// deselected: powered down, sequence abandoned
			state_nxt   = ST_PDOWN;                           // [R16]
			fallCnt_nxt = `QADC_CNT_ZERO;
			riseCnt_nxt = `QADC_CNT_ZERO;
		end else begin
			if (intFall)
				fallCnt_nxt = fallNow;
			if (fallTrack) begin
				// the pending selection takes effect only now
				state_nxt   = ST_TRACK;                       // [R03]
				chanCur_nxt = chanNext_r;                     // [R12] [R15]
				riseCnt_nxt = `QADC_CNT_ZERO;
			end else if (fallHold) begin
				state_nxt   = ST_HOLD;                        // [R04]
			end else if (fallLast) begin
				state_nxt   = ST_PDOWN;                       // [R18]
			end
			if (riseTake)
				riseCnt_nxt = riseNow;
		end
	end

	// control word capture
	always @* begin
		shift_nxt    = shift_r;
		ctrlWord_nxt = ctrlWord_r;
		chanNext_nxt = chanNext_r;
		if (riseCtrl)
			shift_nxt = {shift_r[`QADC_CTRL_W-2:0], dinSync}; // [R11]
		if (wordFull) begin
			// only the complete word updates the selection
			ctrlWord_nxt = shift_nxt;                         // [R21]
			chanNext_nxt =
				shift_nxt[`QADC_CHAN_HI:`QADC_CHAN_LO];       // [R13]
		end
	end

	// serial output bit and converter engine strobes
	always @* begin
		doutBit_nxt = doutBit_r;
		sarStart    = fallHold;
		sarStep     = fallBit;                                // [R06] [R07]
		if (!frameOn)
			doutBit_nxt = 1'b0;
		else if (fallBit)
			doutBit_nxt = sarBit;                             // [R19]
		else if (intFall)
			doutBit_nxt = 1'b0;                               // [R20]
	end

	// result kept and flagged at the sixteenth falling edge
	always @* begin
		lastResult_nxt = lastResult_r;
		done_nxt       = fallLast;                            // [R18]
		if (fallLast)
			lastResult_nxt = sarResult;
	end

	// the sampling capacitor follows the input while tracking
	always @* begin
		sample_nxt = sample_r;
		if (state_r == ST_TRACK)
			sample_nxt = chanMux;                             // [R03]
	end

	// sequencer registers
	always @(posedge sys_clk) begin
		if (!resetn) begin
			state_r    <= ST_PDOWN;
			fallCnt_r  <= `QADC_CNT_ZERO;
			riseCnt_r  <= `QADC_CNT_ZERO;
			chanCur_r  <= `QADC_CHAN_RST;
		end else begin
			state_r    <= state_nxt;
			fallCnt_r  <= fallCnt_nxt;
			riseCnt_r  <= riseCnt_nxt;
			chanCur_r  <= chanCur_nxt;
		end
	end

	// control word registers; selection comes up on input a
	always @(posedge sys_clk) begin
		if (!resetn) begin
			shift_r    <= `QADC_CTRL_RST;
			ctrlWord_r <= `QADC_CTRL_RST;
			chanNext_r <= `QADC_CHAN_RST;                     // [R15] [R21]
		end else begin
			shift_r    <= shift_nxt;
			ctrlWord_r <= ctrlWord_nxt;
			chanNext_r <= chanNext_nxt;
		end
	end

	// held sample and serial output bit
	always @(posedge sys_clk) begin
		if (!resetn) begin
			sample_r  <= `QADC_RES_RST;
			doutBit_r <= 1'b0;
		end else begin
			sample_r  <= sample_nxt;
			doutBit_r <= doutBit_nxt;
		end
	end

	// finished result and its one-cycle flag
	always @(posedge sys_clk) begin
		if (!resetn) begin
			lastResult_r <= `QADC_RES_RST;
			done_r       <= 1'b0;
		end else begin
			lastResult_r <= lastResult_nxt;
			done_r       <= done_nxt;
		end
	end

	// select acts as the output enable
	always @(posedge sys_clk) begin
		if (!resetn)
			doutOe_r <= 1'b0;
		else
			doutOe_r <= frameOn;                                  // [R05]
	end

	assign serialOut   = doutBit_r & doutOe_r;                    // [R05]
	assign serialOutOe = doutOe_r;
	assign trackActive = (state_r == ST_TRACK);
	assign holdActive  = (state_r == ST_HOLD);
	assign powerDown   = (state_r == ST_PDOWN);                   // [R16]
	assign chanSelect  = chanCur_r;
	assign controlWord = ctrlWord_r;
	assign lastResult  = lastResult_r;
	assign resultDone  = done_r;

endmodule // qadc_serial_sequencer
`default_nettype wire

//--- verification/qadc_props.sv
// port checker of the converter sequencer
`default_nettype none
`include "qadc_defines.vh"
module qadc_props (
	// clock and reset
	input wire logic                   sys_clk,
	input wire logic                   resetn,
	// serial pins
	input wire logic                   chipSelN,
	input wire logic                   serialOut,
	input wire logic                   serialOutOe,
	// mode and status
	input wire logic                   trackActive,
	input wire logic                   holdActive,
	input wire logic                   powerDown,
	input wire logic [1:0]             chanSelect,
	input wire logic [`QADC_RES_W-1:0] lastResult,
	input wire logic                   resultDone
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_oe_off; chipSelN [*4] |-> !serialOutOe; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output enabled while deselected");
	property p_oe_on; (!chipSelN) [*4] |-> serialOutOe; endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("output not enabled while selected");
	property p_out_low; !serialOutOe |-> !serialOut; endproperty
	a_out_low: assert property (p_out_low)
		else $error("data driven without enable");
	property p_idle;
		chipSelN [*6] |-> powerDown && !trackActive && !holdActive;
	endproperty
	a_idle: assert property (p_idle)
		else $error("not powered down while deselected");
	property p_modes; !(holdActive && (trackActive || powerDown)); endproperty
	a_modes: assert property (p_modes)
		else $error("hold overlaps another mode");
	property p_track3; $rose(holdActive) |-> $past(trackActive, 16); endproperty
	a_track3: assert property (p_track3)
		else $error("track phase too short");
	property p_hold_len; $rose(holdActive) |=> holdActive [*8]; endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("hold phase too short");
	property p_done_pd; resultDone |-> powerDown && !holdActive; endproperty
	a_done_pd: assert property (p_done_pd)
		else $error("no power down at conversion end");
	property p_done_1; resultDone |=> !resultDone; endproperty
	a_done_1: assert property (p_done_1)
		else $error("done pulse too long");
	property p_hold_end; $fell(holdActive) |-> powerDown; endproperty
	a_hold_end: assert property (p_hold_end)
		else $error("hold left without power down");
	property p_res; $changed(lastResult) |-> resultDone; endproperty
	a_res: assert property (p_res)
		else $error("result changed outside conversion end");
	property p_chan; $changed(chanSelect) |-> trackActive; endproperty
	a_chan: assert property (p_chan)
		else $error("channel changed outside track start");
endmodule // qadc_props
`default_nettype wire

//--- verification/qadc_host.sv
// host serial master model for the converter's serial port
`default_nettype none
module qadc_host (
	// clock
	input  wire logic sys_clk,
	// serial pins
	output var  logic chipSelN,
	output var  logic serialClk,
	output var  logic serialIn,
	input  wire logic serialOut
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy = 1'b0;
	initial begin
		chipSelN = 1'b1;
		serialClk = 1'b0;
		serialIn = 1'b0;
	end
	// released data line keeps changing
	always @(posedge sys_clk) begin
		if (!busy)
			serialIn <= ~serialIn;
	end
	// one frame of nBits clocks, words sent one per conversion
	task automatic frame(input int nBits, input logic [31:0] words,
			input logic idleHi, output logic [63:0] raw);
		logic [7:0] w;
		raw = '0;
		// let the previous frame's last edge pass before touching the pins
		@(posedge sys_clk);
		busy <= 1'b1;
		serialClk <= idleHi;
		repeat (8) @(posedge sys_clk);
		chipSelN <= 1'b0;
		repeat (8) @(posedge sys_clk);
		for (int k = 0; k < nBits; k++) begin
			w = words[8*(k/16) +: 8];
			serialClk <= 1'b0;
			serialIn <= (k % 16 < 8) ? w[7-k%16] : ~serialIn;
			repeat (4) @(posedge sys_clk);
			serialClk <= 1'b1;
			@(negedge sys_clk);
			raw[16*(k/16)+15-k%16] = serialOut;
			repeat (4) @(posedge sys_clk);
		end
		chipSelN <= 1'b1;
		repeat (4) @(posedge sys_clk);
		serialClk <= 1'b0;
		busy <= 1'b0;
	endtask
endmodule // qadc_host
`default_nettype wire

//--- verification/qadc_tb.sv
// self-checking testbench of the converter sequencer
`default_nettype none
`include "qadc_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   sys_clk;
	logic                   resetn;
	wire logic              chipSelN, serialClk, serialIn;
	wire logic              serialOut, serialOutOe, resultDone;
	wire logic              trackActive, holdActive, powerDown;
	wire logic [1:0]        chanSelect;
	wire logic [7:0]        controlWord;
	wire logic [9:0]        lastResult;
	logic      [9:0]        anaIn [0:3];
	logic      [1:0]        expChan = 2'h0;
	int                     mismatches = 0;
	int                     nTests = 0;
	int                     nDone = 0;
	wire logic              hostDout;
	// released output: the host sees a high level, the inverse of the masked serialOut
	assign hostDout = serialOutOe ? serialOut : ~serialOut;
	qadc_serial_sequencer dut_u (.sys_clk, .resetn, .chipSelN, .serialClk,
		.serialIn, .serialOut, .serialOutOe, .analogInputA(anaIn[0]),
		.analogInputB(anaIn[1]), .analogInputC(anaIn[2]),
		.analogInputD(anaIn[3]), .trackActive, .holdActive, .powerDown,
		.chanSelect, .controlWord, .lastResult, .resultDone);
	qadc_host host_u (.sys_clk, .chipSelN, .serialClk, .serialIn,
		.serialOut(hostDout));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (resultDone === 1'b1)
			nDone++;
	end
	task automatic check(input string what, input logic [63:0] seen, exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		if (mismatches == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// frame of n conversions, each result judged against its channel
	task automatic run(input int n, input logic [31:0] words, input logic hi);
		logic [63:0] raw;
		logic [1:0]  used;
		int          d0;
		d0 = nDone;
		host_u.frame(16 * n, words, hi, raw);
		for (int c = 0; c < n; c++) begin
			used = expChan;
			check("bits", raw[16*c +: 16], {4'h0, anaIn[used], 2'b00});
			expChan = words[8*c+3 +: 2];
		end
		check("chan", chanSelect, used);
		check("result", lastResult, anaIn[used]);
		check("word", controlWord, words[8*(n-1) +: 8]);
		check("done", nDone - d0, n);
	endtask
	task automatic t_reset;
		@(negedge sys_clk);
		check("reset", {serialOut, serialOutOe, trackActive, holdActive,
			powerDown, chanSelect, controlWord, lastResult, resultDone},
			{5'b00001, 21'h0});
	endtask
	task automatic t_abort;
		logic [63:0] raw;
		int          d0;
		d0 = nDone;
		host_u.frame(5, 32'h18, 1'b0, raw);
		check("abort", {chanSelect, controlWord}, {expChan, 8'h10});
		check("abort bits", raw[15:11], {4'h0, anaIn[expChan][9]});
		check("abort done", nDone - d0, 0);
	endtask
	initial begin
		resetn <= 1'b0;
		anaIn[0] <= 10'h3ff;
		anaIn[1] <= 10'h000;
		anaIn[2] <= 10'h2aa;
		anaIn[3] <= 10'h155;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset();
		run(1, 32'h08, 1'b0);
		run(4, 32'h0820_38d7, 1'b0);
		run(1, 32'h10, 1'b1);
		t_abort();
		run(1, 32'h00, 1'b0);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end
endmodule // testbench
bind qadc_serial_sequencer qadc_props props_u (.sys_clk, .resetn, .chipSelN,
	.serialOut, .serialOutOe, .trackActive, .holdActive, .powerDown,
	.chanSelect, .lastResult, .resultDone);
`default_nettype wire
